// >>> hdl/iwd_regs.svh
`ifndef IWD_REGS_SVH
`define IWD_REGS_SVH

// Instruction word and field layout
`define IWD_WORD_W      14
`define IWD_FILE_W      7
`define IWD_DATA_W      8
`define IWD_JUMP_W      11
`define IWD_BITSEL_LSB  7
`define IWD_DEST_BIT    7
`define IWD_CLASS_MSB   13
`define IWD_CLASS_LSB   12

// Fixed encodings
`define IWD_ENC_STANDBY 14'h0063
`define IWD_ENC_WDCLEAR 14'h0064
`define IWD_ENC_RETURN  14'h0008
`define IWD_ENC_RETINT  14'h0009

// Oscillator periods per instruction cycle
`define IWD_PHASES      4

// Special file register addresses
`define IWD_ADDR_TIMER0 7'h01
`define IWD_ADDR_PORTA  7'h05
`define IWD_ADDR_PORT_B_REGISTER  7'h06

// Reset values
`define IWD_ACC_RST     8'h00
`define IWD_PC_RST      13'h0000

`endif

// >>> hdl/iwd_pkg.sv
package iwd_pkg;

  typedef enum logic [1:0] {
    IWD_FMT_BYTE = 2'h0,
    IWD_FMT_BIT  = 2'h1,
    IWD_FMT_LIT  = 2'h2
  } iwd_fmt_t;

  typedef enum logic [4:0] {
    IWD_OP_NOP, IWD_OP_MOVWF, IWD_OP_CLR, IWD_OP_SUB, IWD_OP_DEC,
    IWD_OP_IOR, IWD_OP_AND, IWD_OP_XOR, IWD_OP_ADD, IWD_OP_MOV,
    IWD_OP_COM, IWD_OP_INC, IWD_OP_DECSZ, IWD_OP_RRC, IWD_OP_RLC,
    IWD_OP_SWAP, IWD_OP_INCSZ, IWD_OP_BCLR, IWD_OP_BSET, IWD_OP_BTSC,
    IWD_OP_BTSS, IWD_OP_CALL, IWD_OP_GOTO, IWD_OP_MOVL, IWD_OP_RETL,
    IWD_OP_IORL, IWD_OP_ANDL, IWD_OP_XORL, IWD_OP_SUBL, IWD_OP_ADDL,
    IWD_OP_RET, IWD_OP_SLEEP
  } iwd_op_t;

  typedef struct packed {
    iwd_fmt_t    fmt;
    iwd_op_t     op;
    logic        dest_file;
    logic [6:0]  file_addr;
    logic [2:0]  bit_pos;
    logic [10:0] literal;
    logic        reads_file;
    logic        legal;
  } iwd_dec_t;

  // Cycle phase; Gray order along the four oscillator periods
  typedef enum logic [1:0] {
    IWD_Q1 = 2'b00,
    IWD_Q2 = 2'b01,
    IWD_Q3 = 2'b11,
    IWD_Q4 = 2'b10
  } iwd_phase_t;

endpackage

// >>> hdl/iwd_field_decode.sv
`timescale 1ns/10ps
`include "iwd_regs.svh"

module iwd_field_decode (
  // Fetched word
  input  wire logic [13:0]     word,
  // Decoded fields
  output iwd_pkg::iwd_dec_t    dec
);

  logic [1:0] cls;
  logic [3:0] sub;

  assign cls = word[`IWD_CLASS_MSB:`IWD_CLASS_LSB];
  assign sub = word[11:8];

  always_comb begin
    dec            = '0;
    dec.fmt        = iwd_pkg::IWD_FMT_BYTE;
    dec.op         = iwd_pkg::IWD_OP_NOP;
    dec.dest_file  = word[`IWD_DEST_BIT];
    dec.file_addr  = word[`IWD_FILE_W-1:0];
    dec.bit_pos    = word[9:`IWD_BITSEL_LSB];
    dec.literal    = word[`IWD_JUMP_W-1:0];
    dec.legal      = 1'b1;
    dec.reads_file = 1'b0;
    unique case (cls)
      2'h0: begin
        dec.fmt        = iwd_pkg::IWD_FMT_BYTE;
        dec.reads_file = 1'b1;
        unique case (sub)
          4'h0: begin
            if (word[7]) begin
              dec.op = iwd_pkg::IWD_OP_MOVWF;
            end else begin
              dec.reads_file = 1'b0;
              dec.fmt        = iwd_pkg::IWD_FMT_LIT;
              // Bits 6:5 are don't-care only for the plain no-op
              if (word[4:0] == 5'h00) begin
                dec.op = iwd_pkg::IWD_OP_NOP;
              end else if (word == `IWD_ENC_STANDBY) begin
                dec.op = iwd_pkg::IWD_OP_SLEEP;
              end else if (word == `IWD_ENC_RETURN ||
                           word == `IWD_ENC_RETINT) begin
                dec.op = iwd_pkg::IWD_OP_RET;
              end else if (word == `IWD_ENC_WDCLEAR) begin
                dec.op = iwd_pkg::IWD_OP_NOP;
              end else begin
                dec.legal = 1'b0;
              end
            end
          end
          4'h1: dec.op = iwd_pkg::IWD_OP_CLR;
          4'h2: dec.op = iwd_pkg::IWD_OP_SUB;
          4'h3: dec.op = iwd_pkg::IWD_OP_DEC;
          4'h4: dec.op = iwd_pkg::IWD_OP_IOR;
          4'h5: dec.op = iwd_pkg::IWD_OP_AND;
          4'h6: dec.op = iwd_pkg::IWD_OP_XOR;
          4'h7: dec.op = iwd_pkg::IWD_OP_ADD;
          4'h8: dec.op = iwd_pkg::IWD_OP_MOV;
          4'h9: dec.op = iwd_pkg::IWD_OP_COM;
          4'hA: dec.op = iwd_pkg::IWD_OP_INC;
          4'hB: dec.op = iwd_pkg::IWD_OP_DECSZ;
          4'hC: dec.op = iwd_pkg::IWD_OP_RRC;
          4'hD: dec.op = iwd_pkg::IWD_OP_RLC;
          4'hE: dec.op = iwd_pkg::IWD_OP_SWAP;
          4'hF: dec.op = iwd_pkg::IWD_OP_INCSZ;
        endcase
        // Clear of the accumulator ignores the file field
        if (sub == 4'h1 && !word[7]) begin
          dec.reads_file = 1'b0;
        end
      end
      2'h1: begin
        dec.fmt        = iwd_pkg::IWD_FMT_BIT;
        dec.reads_file = 1'b1;
        dec.dest_file  = 1'b1;
        unique case (word[11:10])
          2'h0: dec.op = iwd_pkg::IWD_OP_BCLR;
          2'h1: dec.op = iwd_pkg::IWD_OP_BSET;
          2'h2: dec.op = iwd_pkg::IWD_OP_BTSC;
          2'h3: dec.op = iwd_pkg::IWD_OP_BTSS;
        endcase
      end
      2'h2: begin
        dec.fmt = iwd_pkg::IWD_FMT_LIT;
        dec.op  = word[11] ? iwd_pkg::IWD_OP_GOTO : iwd_pkg::IWD_OP_CALL;
      end
      2'h3: begin
        dec.fmt     = iwd_pkg::IWD_FMT_LIT;
        dec.literal = {3'h0, word[`IWD_DATA_W-1:0]};
        unique casez (sub)
          4'b00??: dec.op = iwd_pkg::IWD_OP_MOVL;
          4'b01??: dec.op = iwd_pkg::IWD_OP_RETL;
          4'b1000: dec.op = iwd_pkg::IWD_OP_IORL;
          4'b1001: dec.op = iwd_pkg::IWD_OP_ANDL;
          4'b1010: dec.op = iwd_pkg::IWD_OP_XORL;
          4'b1011: dec.legal = 1'b0;
          4'b110?: dec.op = iwd_pkg::IWD_OP_SUBL;
          4'b111?: dec.op = iwd_pkg::IWD_OP_ADDL;
        endcase
      end
    endcase
    if (!dec.legal) begin
      dec.op         = iwd_pkg::IWD_OP_NOP;
      dec.reads_file = 1'b0;
    end
  end

endmodule

// >>> hdl/iwd_core.sv
`timescale 1ns/10ps
`include "iwd_regs.svh"

// Operation
// - Accept 14-bit words, opcode plus operands
// - Sort each word into one format
// - Destination bit routes result to accumulator/file
// - File index is seven bits, 0x00-0x7F
// - Bit field picks one register bit
// - Literal is eight or eleven bits
// - Instruction cycle spans four oscillator periods
// - Skips and jumps take two cycles
// - Every file operand is read first
// - Clearing port B rereads, clearing change mismatch
// - Don't-care bits accepted as zero or one
// - Port reads sample pins, not latches
// - Timer-zero write clears assigned prescaler
// - Standby encoding updates timeout/powerdown flags
// - Return-with-literal loads accumulator, returns, two cycles
module iwd_core #(
  parameter int PC_W = 13
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // Program memory
  output logic [PC_W-1:0]       prog_addr,
  input  wire logic [13:0]      prog_word,
  // File register port
  output logic [6:0]            file_addr,
  output logic                  file_rd,
  input  wire logic [7:0]       file_rdata,
  output logic                  file_wr,
  output logic [7:0]            file_wdata,
  // Port pins (already synchronised in the port block)
  input  wire logic [7:0]       pin_level_a,
  input  wire logic [7:0]       pin_level_b,
  // Status and side effects
  input  wire logic             prescaler_on_timer,
  output logic                  prescaler_clear,
  output logic                  port_b_reread,
  output logic                  timeout_flag,
  output logic                  powerdown_flag,
  output logic                  standby,
  output logic [7:0]            accumulator,
  output logic                  carry_flag,
  output logic                  zero_flag,
  // Cycle timing
  output logic                  cycle_start,
  output iwd_pkg::iwd_phase_t   phase
);

  localparam int DEPTH = 8;
  iwd_pkg::iwd_dec_t dec;
  logic [13:0]       instr;
  logic              flush;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   stack [DEPTH];
  logic [2:0]        sp;
  logic [7:0]        operand;
  logic [7:0]        result;
  logic              next_carry;
  logic              skip;
  logic              jump;
  logic              wr_acc;
  logic              wr_file;

  iwd_field_decode u_dec (
    .word (instr),
    .dec  (dec)
  );

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase <= iwd_pkg::IWD_Q1;
    end else begin
      unique case (phase)
        iwd_pkg::IWD_Q1: phase <= iwd_pkg::IWD_Q2;
        iwd_pkg::IWD_Q2: phase <= iwd_pkg::IWD_Q3;
        iwd_pkg::IWD_Q3: phase <= iwd_pkg::IWD_Q4;
        iwd_pkg::IWD_Q4: phase <= iwd_pkg::IWD_Q1;
      endcase
    end
  end

  assign cycle_start = (phase == iwd_pkg::IWD_Q1);

  // ----------------------------------------------------------------
  // Operand read and modify
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_select(input logic [6:0] a,
                                             input logic [7:0] d,
                                             input logic [7:0] pa,
                                             input logic [7:0] pb);
    if (a == `IWD_ADDR_PORTA) begin
      return pa;
    end else if (a == `IWD_ADDR_PORT_B_REGISTER) begin
      return pb;
    end
    return d;
  endfunction

  assign file_addr = dec.file_addr;
  // Read issued for every file operand, even pure writes, except in flush or standby      
  assign file_rd   = !flush && !standby && dec.reads_file &&
                     phase == iwd_pkg::IWD_Q2;
  assign port_b_reread = file_rd &&
                         dec.file_addr == `IWD_ADDR_PORT_B_REGISTER;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      operand <= 8'h00;
    end else if (phase == iwd_pkg::IWD_Q2) begin
      operand <= read_select(dec.file_addr, file_rdata,
                             pin_level_a, pin_level_b);
    end
  end

  always_comb begin
    logic [8:0] sum;
    logic [7:0] lit;
    sum        = 9'h000;
    lit        = dec.literal[7:0];
    result     = 8'h00;
    next_carry = carry_flag;
    skip       = 1'b0;
    jump       = 1'b0;
    wr_acc     = 1'b0;
    wr_file    = 1'b0;
    unique case (dec.op)
      iwd_pkg::IWD_OP_NOP, iwd_pkg::IWD_OP_SLEEP: result = 8'h00;
      iwd_pkg::IWD_OP_MOVWF: begin
        result  = accumulator;
        wr_file = 1'b1;
      end
      iwd_pkg::IWD_OP_CLR: result = 8'h00;
      iwd_pkg::IWD_OP_SUB: begin
        sum        = {1'b0, operand} + {1'b0, ~accumulator} + 9'h001;
        result     = sum[7:0];
        next_carry = sum[8];
      end
      iwd_pkg::IWD_OP_DEC:   result = operand - 8'h01;
      iwd_pkg::IWD_OP_DECSZ: begin
        result = operand - 8'h01;
        skip   = (result == 8'h00);
      end
      iwd_pkg::IWD_OP_INCSZ: begin
        result = operand + 8'h01;
        skip   = (result == 8'h00);
      end
      iwd_pkg::IWD_OP_IOR:  result = operand | accumulator;
      iwd_pkg::IWD_OP_AND:  result = operand & accumulator;
      iwd_pkg::IWD_OP_XOR:  result = operand ^ accumulator;
      iwd_pkg::IWD_OP_ADD: begin
        sum        = {1'b0, operand} + {1'b0, accumulator};
        result     = sum[7:0];
        next_carry = sum[8];
      end
      iwd_pkg::IWD_OP_MOV:  result = operand;
      iwd_pkg::IWD_OP_COM:  result = ~operand;
      iwd_pkg::IWD_OP_INC:  result = operand + 8'h01;
      iwd_pkg::IWD_OP_RRC: begin
        result     = {carry_flag, operand[7:1]};
        next_carry = operand[0];
      end
      iwd_pkg::IWD_OP_RLC: begin
        result     = {operand[6:0], carry_flag};
        next_carry = operand[7];
      end
      iwd_pkg::IWD_OP_SWAP: result = {operand[3:0], operand[7:4]};
      iwd_pkg::IWD_OP_BCLR: begin
        result = operand & ~(8'h01 << dec.bit_pos);
      end
      iwd_pkg::IWD_OP_BSET: begin
        result = operand | (8'h01 << dec.bit_pos);
      end
      iwd_pkg::IWD_OP_BTSC: skip = !operand[dec.bit_pos];
      iwd_pkg::IWD_OP_BTSS: skip = operand[dec.bit_pos];
      iwd_pkg::IWD_OP_CALL: jump = 1'b1;
      iwd_pkg::IWD_OP_GOTO: jump = 1'b1;
      iwd_pkg::IWD_OP_RET:  jump = 1'b1;
      iwd_pkg::IWD_OP_RETL: begin
        result = lit;
        jump   = 1'b1;
        wr_acc = 1'b1;
      end
      iwd_pkg::IWD_OP_MOVL: begin
        result = lit;
        wr_acc = 1'b1;
      end
      iwd_pkg::IWD_OP_IORL: begin
        result = lit | accumulator;
        wr_acc = 1'b1;
      end
      iwd_pkg::IWD_OP_ANDL: begin
        result = lit & accumulator;
        wr_acc = 1'b1;
      end
      iwd_pkg::IWD_OP_XORL: begin
        result = lit ^ accumulator;
        wr_acc = 1'b1;
      end
      iwd_pkg::IWD_OP_SUBL: begin
        sum        = {1'b0, lit} + {1'b0, ~accumulator} + 9'h001;
        result     = sum[7:0];
        next_carry = sum[8];
        wr_acc     = 1'b1;
      end
      iwd_pkg::IWD_OP_ADDL: begin
        sum        = {1'b0, lit} + {1'b0, accumulator};
        result     = sum[7:0];
        next_carry = sum[8];
        wr_acc     = 1'b1;
      end
    endcase
    // Byte ops: destination bit steers the result
    if (dec.fmt == iwd_pkg::IWD_FMT_BYTE && dec.op != iwd_pkg::IWD_OP_MOVWF
        && dec.legal) begin
      wr_file = dec.dest_file;
      wr_acc  = !dec.dest_file;
    end
    if (dec.op == iwd_pkg::IWD_OP_BCLR || dec.op == iwd_pkg::IWD_OP_BSET) begin
      wr_file = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write-back at Q4, suppressed in the flush cycle
  // ----------------------------------------------------------------
  logic commit;
  assign commit     = (phase == iwd_pkg::IWD_Q4) && !flush &&
                      !standby;
  assign file_wr    = commit && wr_file;
  assign prescaler_clear = file_wr && prescaler_on_timer &&
                           dec.file_addr == `IWD_ADDR_TIMER0;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      file_wdata <= 8'h00;
    end else if (phase == iwd_pkg::IWD_Q3) begin
      file_wdata <= result;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      accumulator <= `IWD_ACC_RST;
      carry_flag  <= 1'b0;
      zero_flag   <= 1'b0;
    end else if (commit) begin
      if (wr_acc) begin
        accumulator <= result;
      end
      carry_flag <= next_carry;
      if (wr_acc || wr_file) begin
        zero_flag <= (result == 8'h00);
      end
    end
  end

  // Flags active low; standby is a Q4 one-shot entry
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
      standby        <= 1'b0;
    end else if (commit && dec.op == iwd_pkg::IWD_OP_SLEEP) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
      standby        <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fetch, program counter and flush
  // ----------------------------------------------------------------
  assign prog_addr = pc;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pc    <= `IWD_PC_RST;
      instr <= 14'h0000;
      flush <= 1'b1;
      sp    <= 3'h0;
    end else if (phase == iwd_pkg::IWD_Q4 && !standby) begin
      instr <= prog_word;
      pc    <= pc + 1'b1;
      flush <= 1'b0;
      if (!flush && (skip || jump)) begin
        flush <= 1'b1;
        if (instr[`IWD_CLASS_MSB:`IWD_CLASS_LSB] == 2'h2) begin
          pc <= PC_W'(dec.literal);
        end else if (jump) begin
          pc <= stack[sp - 3'h1];
          sp <= sp - 3'h1;
        end
        if (dec.op == iwd_pkg::IWD_OP_CALL) begin
          sp <= sp + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (commit && dec.op == iwd_pkg::IWD_OP_CALL) begin
      stack[sp] <= pc;
    end
  end

  chk_flush_after_jump: assert property (@(posedge mclk) disable iff (!rstn)
    commit && jump |=> flush [*4]) else $error("no flush after jump");
  chk_flush_no_write: assert property (@(posedge mclk) disable iff (!rstn)
    flush |-> !file_wr) else $error("write in flush cycle");
  chk_read_before_write: assert property (@(posedge mclk) disable iff (!rstn)
    file_wr |-> $past(file_rd, 2) || $past(flush, 2) ||
    dec.op == iwd_pkg::IWD_OP_MOVWF) else $error("write without read");
  chk_phase_period: assert property (@(posedge mclk) disable iff (!rstn)
    cycle_start |=> !cycle_start [*3] ##1 cycle_start)
    else $error("cycle not four periods");
  chk_timer_clear: assert property (@(posedge mclk) disable iff (!rstn)
    file_wr && file_addr == `IWD_ADDR_TIMER0 && prescaler_on_timer
    |-> prescaler_clear) else $error("prescaler not cleared");
  chk_sleep_flags: assert property (@(posedge mclk) disable iff (!rstn)
    commit && dec.op == iwd_pkg::IWD_OP_SLEEP
    |=> !powerdown_flag && timeout_flag && standby)
    else $error("standby flags wrong");
  chk_dest_acc: assert property (@(posedge mclk) disable iff (!rstn)
    commit && dec.fmt == iwd_pkg::IWD_FMT_BYTE && dec.legal &&
    !dec.dest_file |-> !file_wr) else $error("d=0 wrote file");
  chk_illegal_nop: assert property (@(posedge mclk) disable iff (!rstn)
    !dec.legal |-> !file_wr && !file_rd && !jump && !skip)
    else $error("illegal word had effect");
  chk_standby_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    standby |-> !file_rd && !file_wr) else $error("busy in standby");

endmodule

// >>> test/iwd_prog_mem.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Program memory model
// ------------------------------------------------------------
module iwd_prog_mem (
  // Fetch side
  input  wire logic [12:0] prog_addr,
  output logic [13:0]      prog_word
);
  // Only 64 words are modelled; higher addresses alias
  logic [13:0] mem [0:63];

  assign prog_word = mem[prog_addr[5:0]];
endmodule

// >>> test/tb_top.sv
`timescale 1ns/10ps

module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                mclk;
  logic                rstn;
  logic [12:0]         prog_addr;
  logic [13:0]         prog_word;
  logic [6:0]          file_addr;
  logic                file_rd;
  logic [7:0]          file_rdata;
  logic                file_wr;
  logic [7:0]          file_wdata;
  logic [7:0]          pin_level_a;
  logic [7:0]          pin_level_b;
  logic                prescaler_on_timer;
  logic                prescaler_clear;
  logic                port_b_reread;
  logic                timeout_flag;
  logic                powerdown_flag;
  logic                standby;
  logic [7:0]          accumulator;
  logic                carry_flag;
  logic                zero_flag;
  logic                cycle_start;
  iwd_pkg::iwd_phase_t phase;
  logic [7:0]          fmem [0:127];
  logic [6:0]          wa [$];
  logic [7:0]          wd [$];
  int                  wt [$];
  logic [6:0]          ra [$];
  int                  num_errors;
  int                  n_compared;
  int                  cyc;
  int                  rb_cnt;
  int                  ps_cnt;

  iwd_prog_mem u_pm (.prog_addr(prog_addr), .prog_word(prog_word));

  iwd_core u_dut (
    .mclk(mclk), .rstn(rstn), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_addr(file_addr), .file_rd(file_rd),
    .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata),
    .pin_level_a(pin_level_a), .pin_level_b(pin_level_b),
    .prescaler_on_timer(prescaler_on_timer),
    .prescaler_clear(prescaler_clear), .port_b_reread(port_b_reread),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
    .standby(standby), .accumulator(accumulator),
    .carry_flag(carry_flag), .zero_flag(zero_flag),
    .cycle_start(cycle_start), .phase(phase)
  );

  // ------------------------------------------------------------
  // Clock, file model and monitor
  // ------------------------------------------------------------
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Outside a read strobe the data lines carry a moving pattern
  assign file_rdata = file_rd ? fmem[file_addr] : (8'h5A ^ cyc[7:0]);

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rstn && file_wr) begin
      wa.push_back(file_addr);
      wd.push_back(file_wdata);
      wt.push_back(cyc);
    end
    if (rstn && file_rd) ra.push_back(file_addr);
    if (rstn && port_b_reread) rb_cnt++;
    if (rstn && prescaler_clear) ps_cnt++;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic boot();
    @(negedge mclk);
    rstn = 1'b0;
    repeat (20) @(negedge mclk);
    wa.delete();
    wd.delete();
    wt.delete();
    ra.delete();
    rb_cnt = 0;
    ps_cnt = 0;
    rstn = 1'b1;
  endtask

  task automatic wait_writes(input int n);
    int i;
    for (i = 0; i < 400 && wa.size() < n; i++) @(negedge mclk);
    if (wa.size() < n) begin
      num_errors++;
      $display("[FAIL] %0t write wait timed out", $time);
      results();
    end
    repeat (16) @(negedge mclk);
    check(wa.size() == n, "write count");
  endtask

  task automatic exp_w(input int i, input logic [6:0] a,
                       input logic [7:0] d);
    check(wa[i] === a && wd[i] === d, "write address or data");
  endtask

  task automatic clear_prog();
    foreach (u_pm.mem[i]) u_pm.mem[i] = 14'h0000;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_byte_ops();
    clear_prog();
    u_pm.mem[0] = 14'h335A;
    u_pm.mem[1] = 14'h00FF;
    u_pm.mem[2] = 14'h0720;
    u_pm.mem[3] = 14'h06A1;
    u_pm.mem[4] = 14'h3E21;
    boot();
    wait_writes(2);
    exp_w(0, 7'h7F, 8'h5A);
    exp_w(1, 7'h21, 8'h5B);
    check(accumulator === 8'h00 && carry_flag === 1'b1 &&
          zero_flag === 1'b1, "accumulator and status");
    check(ra.size() == 3 && ra[0] === 7'h7F, "read first");
    check(wt[1] - wt[0] == 8, "cycle length");
  endtask

  task automatic s_branch();
    clear_prog();
    u_pm.mem[0] = 14'h2803;
    u_pm.mem[1] = 14'h00B0;
    u_pm.mem[2] = 14'h00B1;
    u_pm.mem[3] = 14'h3011;
    u_pm.mem[4] = 14'h00B2;
    u_pm.mem[5] = 14'h18C0;
    u_pm.mem[6] = 14'h00B3;
    u_pm.mem[7] = 14'h1CC0;
    u_pm.mem[8] = 14'h00B4;
    boot();
    wait_writes(2);
    exp_w(0, 7'h32, 8'h11);
    exp_w(1, 7'h34, 8'h11);
    check(wt[1] - wt[0] == 16, "skip timing");
  endtask

  task automatic s_call_standby();
    clear_prog();
    u_pm.mem[0] = 14'h2004;
    u_pm.mem[1] = 14'h00B5;
    u_pm.mem[2] = 14'h0063;
    u_pm.mem[3] = 14'h00B6;
    u_pm.mem[4] = 14'h3477;
    boot();
    check(timeout_flag === 1'b1 && powerdown_flag === 1'b1,
          "reset flags");
    check(standby === 1'b0, "standby at reset");
    wait_writes(1);
    exp_w(0, 7'h35, 8'h77);
    check(accumulator === 8'h77, "literal return");
    check(standby === 1'b1, "standby entered");
    check(timeout_flag === 1'b1 && powerdown_flag === 1'b0,
          "standby flags");
  endtask

  task automatic s_ports();
    clear_prog();
    u_pm.mem[0] = 14'h0886;
    u_pm.mem[1] = 14'h0186;
    u_pm.mem[2] = 14'h0081;
    u_pm.mem[3] = 14'h3B00;
    u_pm.mem[4] = 14'h15A2;
    u_pm.mem[5] = 14'h0885;
    pin_level_a = 8'hC3;
    pin_level_b = 8'h3C;
    prescaler_on_timer = 1'b1;
    boot();
    wait_writes(5);
    exp_w(0, 7'h06, 8'h3C);
    exp_w(1, 7'h06, 8'h00);
    exp_w(2, 7'h01, 8'h00);
    exp_w(3, 7'h22, 8'h8F);
    exp_w(4, 7'h05, 8'hC3);
    check(rb_cnt == 2, "port b rereads");
    check(ps_cnt == 1, "prescaler clears");
    check(wt[3] - wt[2] == 8, "illegal word one cycle");
    check(accumulator === 8'h00, "accumulator kept");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    pin_level_a = 8'h00;
    pin_level_b = 8'h00;
    prescaler_on_timer = 1'b0;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    rb_cnt = 0;
    ps_cnt = 0;
    foreach (fmem[i]) fmem[i] = 8'(i) ^ 8'hA5;
    clear_prog();
    s_byte_ops();
    s_branch();
    s_call_standby();
    s_ports();
    results();
  end
endmodule
